/* File: hdl/cob_pkg.sv */
// Constants, types and helpers of the control output parameter bank.
// Assumes one 25 MHz clock and synchronous active-high reset.
package cob_pkg;
  // Clock and time base
  localparam int CLK_NS  = 40;
  localparam int TICK_NS = 50_000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICKS_PER_SEC_STEP = 20;  // 1 ms step per second of cycle
  localparam logic [11:0] STEP_U1 = 12'h000A;  // 0.5 ms steps
  localparam logic [11:0] STEP_U2 = 12'h0005;  // 0.25 ms steps
  localparam logic [11:0] STEP_U3 = 12'h0002;  // 0.1 ms steps
  localparam logic [9:0]  POS_LAST = 10'h03E7; // 1000 steps per cycle

  // Register offsets
  localparam logic [3:0] A_METHOD = 4'h0;
  localparam logic [3:0] A_AT_LO  = 4'h1;
  localparam logic [3:0] A_AT_HI  = 4'h2;
  localparam logic [3:0] A_HYST   = 4'h3;
  localparam logic [3:0] A_ACTION_POINT_OFFSET   = 4'h4;
  localparam logic [3:0] A_CYU1   = 4'h5;
  localparam logic [3:0] A_CY1    = 4'h6;
  localparam logic [3:0] A_CYCLE_UNIT_SECOND   = 4'h7;
  localparam logic [3:0] A_CY2    = 4'h8;
  localparam logic [3:0] A_STATUS = 4'h9;

  // Ranges and reset values (percent in tenths, cycle lengths in seconds)
  localparam logic [15:0] AT_MIN    = 16'hFF9C;
  localparam logic [15:0] AT_MAX    = 16'h044C;
  localparam logic [15:0] AT_LO_RST = 16'h0000;
  localparam logic [15:0] AT_HI_RST = 16'h03E8;
  localparam logic [15:0] MV_ZERO   = 16'h0000;
  localparam logic [15:0] MV_FULL   = 16'h03E8;
  localparam logic [15:0] HYS_MAX   = 16'h270F;
  localparam logic [15:0] HYS_RST   = 16'h0005;
  localparam logic [15:0] OFS_MIN   = 16'hF831;
  localparam logic [15:0] OFS_MAX   = 16'h270F;
  localparam logic [15:0] OFS_RST   = 16'h0000;
  localparam logic [15:0] CY_MAX    = 16'h0078;
  localparam logic [15:0] CY_MIN_RL = 16'h0005;
  localparam logic [15:0] CY_MIN    = 16'h0001;
  localparam logic [15:0] CY_RST_RL = 16'h000A;
  localparam logic [15:0] CY_RST    = 16'h0002;
  localparam logic [1:0]  UNIT_SEC  = 2'h0;
  localparam logic [1:0]  UNIT_MAX  = 2'h3;
  localparam logic        METHOD_ONOFF = 1'b0;
  localparam logic        METHOD_PID   = 1'b1;

  typedef enum logic [1:0] {COB_ON = 2'b01, COB_OFF = 2'b10} cob_onoff_t;

  typedef struct packed {
    logic        single_point; // one control output point
    logic        out_relay;    // control output is a relay
    logic        mv1_relay;    // heat destination holds a relay
    logic        mv2_relay;    // cool destination holds a relay
    logic        mv1_routed;   // heat on relay/pulse/event output
    logic        mv2_routed;   // cool on relay/pulse/event output
    logic        heat_cool_select;
  } cob_strap_t;

  typedef struct packed {
    logic        method;
    logic [15:0] at_lo;
    logic [15:0] at_hi;
    logic [15:0] on_off_hysteresis;
    logic [15:0] action_point_offset;
    logic [1:0]  cycle_unit_first;
    logic [15:0] cycle_length_first;
    logic [1:0]  cycle_unit_second;
    logic [15:0] cycle_length_second;
  } cob_cfg_t;

  typedef struct packed {
    cob_cfg_t    cfg;
    cob_onoff_t  onoff;
    logic [10:0] tick_cnt;
    logic        tick;
    logic        heat;
    logic        cool;
    logic [15:0] rdata;
  } cob_state_t;

  typedef struct packed {
    logic [11:0] div_cnt;
    logic [9:0]  pos;
    logic        out;
  } cob_tp_state_t;

  // Signed clamp of a value into [lo, hi]
  function automatic logic [15:0] cob_clamp(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if ($signed(v) < $signed(lo)) r = lo;
    if ($signed(v) > $signed(hi)) r = hi;
    return r;
  endfunction : cob_clamp

  // Ticks of the 50 us base per 1/1000 of a cycle
  function automatic logic [11:0] cob_step(input logic [1:0]  u,
                                           input logic [15:0] cy);
    logic [11:0] s;
    s = STEP_U1;
    case (u)
      2'h0: s = 12'(int'(cy[6:0]) * TICKS_PER_SEC_STEP);
      2'h1: s = STEP_U1;
      2'h2: s = STEP_U2;
      default: s = STEP_U3;
    endcase
    return s;
  endfunction : cob_step
endpackage : cob_pkg

/* File: hdl/cob_top.sv */
// Output stage parameter bank: ON/OFF or PID selection, ON/OFF switching,
// auto-tuning MV limits and two time-proportional outputs.
// Assumes straps are static and software uses the plain register port.
module cob_top
  import cob_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WR_DATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [15:0] RD_DATA,
  input  wire cob_strap_t  STRAP,
  input  wire logic        AUTO_TUNING,
  input  wire logic [15:0] PV,
  input  wire logic [15:0] SP,
  input  wire logic [15:0] HEAT_SIDE_OUTPUT,
  input  wire logic [15:0] COOL_SIDE_OUTPUT,
  output logic             HEAT_OUT,
  output logic             COOL_OUT
);
  cob_state_t  st_r, st_nxt;
  cob_cfg_t    cfg;
  logic [15:0] mv1_eff, mv2_eff;
  logic [15:0] duty1, duty2;
  logic [11:0] step1, step2;
  logic        tp1, tp2;
  logic        at_clamp;
  logic        onoff_mode;
  logic [15:0] cy1_min, cy2_min;
  logic signed [17:0] pv_x, point, point_lo;

  assign cfg        = st_r.cfg;
  assign onoff_mode = (cfg.method == METHOD_ONOFF);

  // Limits only count in PID mode while tuning runs
  assign at_clamp = AUTO_TUNING && !onoff_mode;
  assign mv1_eff  = at_clamp ?
                    cob_clamp(HEAT_SIDE_OUTPUT, cfg.at_lo, cfg.at_hi) :
                    HEAT_SIDE_OUTPUT;
  assign mv2_eff  = at_clamp ?
                    cob_clamp(COOL_SIDE_OUTPUT, cfg.at_lo, cfg.at_hi) :
                    COOL_SIDE_OUTPUT;
  // Pulse width cannot go below zero or past a full cycle
  assign duty1 = cob_clamp(mv1_eff, MV_ZERO, MV_FULL);
  assign duty2 = cob_clamp(mv2_eff, MV_ZERO, MV_FULL);

  // Cycle steps; unit setting overrides the seconds value
  assign step1 = cob_step(cfg.cycle_unit_first,
                          cfg.cycle_length_first);
  assign step2 = cob_step(cfg.cycle_unit_second,
                          cfg.cycle_length_second);

  // Lower cycle bound depends on relay in the destination
  assign cy1_min = STRAP.mv1_relay ? CY_MIN_RL : CY_MIN;
  assign cy2_min = STRAP.mv2_relay ? CY_MIN_RL : CY_MIN;

  // Shifted switch point and the lower edge of the band
  assign pv_x     = {{2{PV[15]}}, PV};
  assign point    = {{2{SP[15]}}, SP} +
                    {{2{cfg.action_point_offset[15]}},
                     cfg.action_point_offset};
  assign point_lo = point - {2'b00, cfg.on_off_hysteresis};

  cob_tprop u_tp1 (
    .clk      (SYS_CLK),
    .srst     (SRST),
    .tick     (st_r.tick),
    .en       (STRAP.mv1_routed),
    .step_div (step1),
    .duty     (duty1),
    .out      (tp1)
  );

  cob_tprop u_tp2 (
    .clk      (SYS_CLK),
    .srst     (SRST),
    .tick     (st_r.tick),
    .en       (STRAP.heat_cool_select && STRAP.mv2_routed),
    .step_div (step2),
    .duty     (duty2),
    .out      (tp2)
  );

  // Next state: tick divider, register writes, ON/OFF switch, outputs
  always_comb begin
    st_nxt = st_r;
    // 50 us base tick
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt >= 11'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 11'h000;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 11'h001;
    end

    // Writes out of range are dropped so settings stay legal
    if (WR_STB) begin
      unique case (ADDR)
        A_METHOD:
          if (WR_DATA[15:1] == 15'h0000)
            st_nxt.cfg.method = WR_DATA[0];
        A_AT_LO:
          if ($signed(WR_DATA) >= $signed(AT_MIN) &&
              $signed(WR_DATA) <= $signed(AT_MAX))
            st_nxt.cfg.at_lo = WR_DATA;
        A_AT_HI:
          if ($signed(WR_DATA) >= $signed(AT_MIN) &&
              $signed(WR_DATA) <= $signed(AT_MAX))
            st_nxt.cfg.at_hi = WR_DATA;
        A_HYST:
          if (WR_DATA <= HYS_MAX)
            st_nxt.cfg.on_off_hysteresis = WR_DATA;
        A_ACTION_POINT_OFFSET:
          if ($signed(WR_DATA) >= $signed(OFS_MIN) &&
              $signed(WR_DATA) <= $signed(OFS_MAX))
            st_nxt.cfg.action_point_offset = WR_DATA;
        A_CYU1:
          if (WR_DATA <= {14'h0000, UNIT_MAX})
            st_nxt.cfg.cycle_unit_first = WR_DATA[1:0];
        A_CY1:
          if (cfg.cycle_unit_first == UNIT_SEC &&
              WR_DATA >= cy1_min && WR_DATA <= CY_MAX)
            st_nxt.cfg.cycle_length_first = WR_DATA;
        A_CYCLE_UNIT_SECOND:
          if (WR_DATA <= {14'h0000, UNIT_MAX})
            st_nxt.cfg.cycle_unit_second = WR_DATA[1:0];
        A_CY2:
          if (cfg.cycle_unit_second == UNIT_SEC &&
              WR_DATA >= cy2_min && WR_DATA <= CY_MAX)
            st_nxt.cfg.cycle_length_second = WR_DATA;
        default: ;
      endcase
    end

    // Read data valid the cycle after the strobe, zero otherwise
    st_nxt.rdata = 16'h0000;
    if (RD_STB) begin
      unique case (ADDR)
        A_METHOD: st_nxt.rdata = {15'h0000, cfg.method};
        A_AT_LO:  st_nxt.rdata = cfg.at_lo;
        A_AT_HI:  st_nxt.rdata = cfg.at_hi;
        A_HYST:   st_nxt.rdata = cfg.on_off_hysteresis;
        A_ACTION_POINT_OFFSET:   st_nxt.rdata = cfg.action_point_offset;
        A_CYU1:   st_nxt.rdata = {14'h0000, cfg.cycle_unit_first};
        A_CY1:    st_nxt.rdata = cfg.cycle_length_first;
        A_CYCLE_UNIT_SECOND:   st_nxt.rdata = {14'h0000, cfg.cycle_unit_second};
        A_CY2:    st_nxt.rdata = cfg.cycle_length_second;
        A_STATUS: st_nxt.rdata = {5'h00, STRAP, at_clamp,
                                  st_r.onoff == COB_ON,
                                  st_r.cool, st_r.heat};
        default:  st_nxt.rdata = 16'h0000;
      endcase
    end

    // Dead band between point_lo and point keeps the relay quiet
    unique case (st_r.onoff)
      COB_ON:  if (pv_x > point)    st_nxt.onoff = COB_OFF;
      COB_OFF: if (pv_x < point_lo) st_nxt.onoff = COB_ON;
      default: st_nxt.onoff = COB_OFF;
    endcase

    // Heat follows ON/OFF or the pulse train; cool needs PID
    st_nxt.heat = STRAP.mv1_routed &&
                  (onoff_mode ? (st_r.onoff == COB_ON) : tp1);
    st_nxt.cool = STRAP.heat_cool_select && STRAP.mv2_routed &&
                  !onoff_mode && tp2;
  end

  // Reset values depend on the output straps
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_r <= '0;
      st_r.onoff <= COB_OFF;
      st_r.cfg.method <= (STRAP.single_point && STRAP.out_relay) ?
                         METHOD_ONOFF : METHOD_PID;
      st_r.cfg.at_lo <= AT_LO_RST;
      st_r.cfg.at_hi <= AT_HI_RST;
      st_r.cfg.on_off_hysteresis <= HYS_RST;
      st_r.cfg.action_point_offset <= OFS_RST;
      st_r.cfg.cycle_unit_first <= UNIT_SEC;
      st_r.cfg.cycle_unit_second <= UNIT_SEC;
      st_r.cfg.cycle_length_first <= STRAP.out_relay ?
                                     CY_RST_RL : CY_RST;
      st_r.cfg.cycle_length_second <= STRAP.single_point ?
                                      CY_RST_RL : CY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RD_DATA  = st_r.rdata;
  assign HEAT_OUT = st_r.heat;
  assign COOL_OUT = st_r.cool;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  method_reset_a: assert property ($past(SRST) |->
    cfg.method == !(STRAP.single_point && STRAP.out_relay))
    else $error("method reset value wrong");
  cycle_reset_a: assert property ($past(SRST) |->
    cfg.cycle_length_first == (STRAP.out_relay ? CY_RST_RL : CY_RST) &&
    cfg.cycle_length_second ==
      (STRAP.single_point ? CY_RST_RL : CY_RST))
    else $error("cycle reset value wrong");
  at_limit_a: assert property (at_clamp &&
    $signed(HEAT_SIDE_OUTPUT) > $signed(cfg.at_hi) |-> mv1_eff == cfg.at_hi)
    else $error("tuning high limit not applied");
  hyst_range_a: assert property (cfg.on_off_hysteresis <= HYS_MAX)
    else $error("hysteresis out of range");
  offset_range_a: assert property (
    $signed(cfg.action_point_offset) >= $signed(OFS_MIN) &&
    $signed(cfg.action_point_offset) <= $signed(OFS_MAX))
    else $error("offset out of range");
  unit_step_a: assert property (
    cfg.cycle_unit_first == 2'h3 |-> step1 == STEP_U3)
    else $error("fixed cycle step wrong");
  cycle_lock_a: assert property (WR_STB && ADDR == A_CY1 &&
    cfg.cycle_unit_first != UNIT_SEC |=> $stable(cfg.cycle_length_first))
    else $error("locked cycle changed");
  cy1_range_a: assert property (WR_STB && ADDR == A_CY1 &&
    WR_DATA < cy1_min |=> $stable(cfg.cycle_length_first))
    else $error("short first cycle accepted");
  cy2_range_a: assert property (WR_STB && ADDR == A_CY2 &&
    WR_DATA > CY_MAX |=> $stable(cfg.cycle_length_second))
    else $error("long second cycle accepted");
  cool_gate_a: assert property (COOL_OUT |->
    STRAP.heat_cool_select && STRAP.mv2_routed)
    else $error("cool output without routing");
  heat_gate_a: assert property (!STRAP.mv1_routed |=> !HEAT_OUT)
    else $error("heat output without routing");
  onoff_hold_a: assert property (st_r.onoff == COB_ON &&
    pv_x <= point |=> st_r.onoff == COB_ON)
    else $error("ON/OFF switched inside band");

  onoff_cyc_c: cover property (st_r.onoff == COB_ON ##1 st_r.onoff == COB_OFF);
  at_clamp_c: cover property (at_clamp && mv1_eff != HEAT_SIDE_OUTPUT);
  cool_on_c: cover property ($rose(COOL_OUT));
endmodule : cob_top

/* File: hdl/cob_tprop.sv */
// Time-proportional pulse generator for one manipulated variable.
// Assumes a one-cycle tick every 50 us and a duty in tenths of percent.
module cob_tprop
  import cob_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        tick,
  input  wire logic        en,
  input  wire logic [11:0] step_div,
  input  wire logic [15:0] duty,
  output logic             out
);
  cob_tp_state_t st_r, st_nxt;

  // Step counter walks 1000 positions; output high while below duty
  always_comb begin
    st_nxt = st_r;
    if (tick) begin
      if (st_r.div_cnt + 12'h0001 >= step_div) begin
        st_nxt.div_cnt = 12'h0000;
        st_nxt.pos = (st_r.pos >= POS_LAST) ? 10'h000 : st_r.pos + 10'h001;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 12'h0001;
      end
    end
    st_nxt.out = en && ({6'h00, st_r.pos} < duty);
  end

  always_ff @(posedge clk) begin
    if (srst) st_r <= '0;
    else      st_r <= st_nxt;
  end

  assign out = st_r.out;

  pulse_duty_a: assert property (@(posedge clk) disable iff (srst)
    en && ({6'h00, st_r.pos} < duty) |=> out)
    else $error("pulse not high inside duty window");
  pulse_off_a: assert property (@(posedge clk) disable iff (srst)
    !en || ({6'h00, st_r.pos} >= duty) |=> !out)
    else $error("pulse high outside duty window");
endmodule : cob_tprop

/* File: verif/cob_act_model.sv */
// Actuator model on one drive line: counts cycles the coil is energised.
// Assumes the bench pulses clr for one cycle to open a counting window.
module cob_act_model (
  input  wire logic clk,
  input  wire logic clr,
  input  wire logic drive,
  output int        on_cnt,
  output int        tot_cnt
);
  timeunit 1ns;
  timeprecision 100ps;

  // Coil only pulls in on a clean high; an unknown level counts as off
  always_ff @(posedge clk) begin
    if (clr) begin
      on_cnt  <= 0;
      tot_cnt <= 0;
    end else begin
      tot_cnt <= tot_cnt + 1;
      if (drive === 1'b1) on_cnt <= on_cnt + 1;
    end
  end
endmodule : cob_act_model

/* File: verif/testbench.sv */
// Self-checking bench of the output stage parameter bank.
// Assumes a 25 MHz clock; straps change only under reset.
module testbench;
  import cob_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 10000;  // Whole run needs about 2000 cycles
  logic        sys_clk, srst, wr_stb, rd_stb, auto_tuning, clr;
  logic [3:0]  addr;
  logic [15:0] wr_data, rd_data, pv, sp, heat_mv, cool_mv;
  logic        heat_out, cool_out;
  cob_strap_t  strap;
  int          err_count, checks, cyc, on_h, tot_h, on_c, tot_c;

  cob_top dut (.SYS_CLK(sys_clk), .SRST(srst), .ADDR(addr),
    .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .STRAP(strap), .AUTO_TUNING(auto_tuning), .PV(pv), .SP(sp),
    .HEAT_SIDE_OUTPUT(heat_mv), .COOL_SIDE_OUTPUT(cool_mv),
    .HEAT_OUT(heat_out), .COOL_OUT(cool_out));
  cob_act_model heat_act (.clk(sys_clk), .clr(clr), .drive(heat_out),
    .on_cnt(on_h), .tot_cnt(tot_h));
  cob_act_model cool_act (.clk(sys_clk), .clr(clr), .drive(cool_out),
    .on_cnt(on_c), .tot_cnt(tot_c));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard: a stalled run still reaches the verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Straps are sampled at the reset edge, so they change only here
  task automatic rst(input cob_strap_t s);
    @(posedge sys_clk);
    srst  <= 1'b1;
    strap <= s;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
  endtask : rst

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_stb  <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rc(input string nm, input logic [3:0] a,
                    input logic [15:0] e);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 chk(nm, e, rd_data);
  endtask : rc

  task automatic wc(input string nm, input logic [3:0] a,
                    input logic [15:0] d, input logic [15:0] e);
    wr(a, d);
    rc(nm, a, e);
  endtask : wc

  // Settle, then count a 200-cycle window on both actuators
  task automatic win(input bit eh, input bit ec);
    repeat (8) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (200) @(posedge sys_clk);
    #1 chk("heat_on", 16'(eh ? tot_h : 0), 16'(on_h));
    chk("cool_on", 16'(ec ? tot_c : 0), 16'(on_c));
  endtask : win

  task automatic oo(input logic [15:0] v, input logic e);
    @(posedge sys_clk);
    pv <= v;
    repeat (4) @(posedge sys_clk);
    #1 chk("heat_onoff", {15'h0000, e}, {15'h0000, heat_out});
  endtask : oo

  task automatic t_reset_relay();
    rc("method", A_METHOD, 16'h0000);
    rc("at_lo", A_AT_LO, AT_LO_RST);
    rc("at_hi", A_AT_HI, AT_HI_RST);
    rc("hyst", A_HYST, HYS_RST);
    rc("action_point_offset", A_ACTION_POINT_OFFSET, OFS_RST);
    rc("unit1", A_CYU1, 16'h0000);
    rc("cy1", A_CY1, CY_RST_RL);
    rc("unit2", A_CYCLE_UNIT_SECOND, 16'h0000);
    rc("cy2", A_CY2, CY_RST_RL);
    rc("unmapped", 4'hC, 16'h0000);
  endtask : t_reset_relay

  task automatic t_relay_limits();
    wc("cy1", A_CY1, 16'h0004, CY_RST_RL);
    wc("cy1", A_CY1, CY_MIN_RL, CY_MIN_RL);
    wc("cy2", A_CY2, 16'h0004, CY_RST_RL);
    wc("cy2", A_CY2, CY_MIN_RL, CY_MIN_RL);
  endtask : t_relay_limits

  // Point 100, band 5, then point moved to 120
  task automatic t_onoff();
    oo(16'h005A, 1'b1);
    oo(16'h0064, 1'b1);
    oo(16'h0065, 1'b0);
    oo(16'h0060, 1'b0);
    oo(16'h005E, 1'b1);
    wr(A_ACTION_POINT_OFFSET, 16'h0014);
    oo(16'h0079, 1'b0);
    oo(16'h0074, 1'b0);
    oo(16'h0072, 1'b1);
  endtask : t_onoff

  task automatic t_reset_plain();
    rc("method", A_METHOD, 16'h0001);
    rc("cy1", A_CY1, CY_RST);
    rc("cy2", A_CY2, CY_RST);
  endtask : t_reset_plain

  task automatic t_limits();
    wc("at_lo", A_AT_LO, 16'hFF9B, AT_LO_RST);
    wc("at_lo", A_AT_LO, AT_MIN, AT_MIN);
    wc("at_hi", A_AT_HI, 16'h044D, AT_HI_RST);
    wc("at_hi", A_AT_HI, AT_MAX, AT_MAX);
    wc("hyst", A_HYST, 16'h2710, HYS_RST);
    wc("hyst", A_HYST, HYS_MAX, HYS_MAX);
    wc("action_point_offset", A_ACTION_POINT_OFFSET, 16'hF830, OFS_RST);
    wc("action_point_offset", A_ACTION_POINT_OFFSET, OFS_MIN, OFS_MIN);
    wc("action_point_offset", A_ACTION_POINT_OFFSET, OFS_MAX, OFS_MAX);
    wc("method", A_METHOD, 16'h0002, 16'h0001);
    wc("method", A_METHOD, 16'h0000, 16'h0000);
    wc("method", A_METHOD, 16'h0001, 16'h0001);
    wc("cy1", A_CY1, 16'h0000, CY_RST);
    wc("cy1", A_CY1, CY_MIN, CY_MIN);
    wc("cy1", A_CY1, 16'h0079, CY_MIN);
    wc("cy1", A_CY1, CY_MAX, CY_MAX);
    wc("cy2", A_CY2, 16'h0000, CY_RST);
    wc("cy2", A_CY2, CY_MIN, CY_MIN);
    wc("cy2", A_CY2, 16'h0079, CY_MIN);
    wc("cy2", A_CY2, CY_MAX, CY_MAX);
  endtask : t_limits

  // Leaves both units at 3, the shortest fixed cycle
  task automatic t_units();
    for (int u = 0; u < 4; u++) begin
      wc("unit1", A_CYU1, 16'(u), 16'(u));
      wc("unit2", A_CYCLE_UNIT_SECOND, 16'(u), 16'(u));
    end
    wc("cy1", A_CY1, 16'h0032, CY_MAX);
    wc("cy2", A_CY2, 16'h0032, CY_MAX);
  endtask : t_units

  // Full and zero MV only: a whole cycle is far longer than the run
  task automatic t_pulse();
    heat_mv <= MV_FULL;
    win(1'b1, 1'b0);
    heat_mv <= MV_ZERO;
    cool_mv <= MV_FULL;
    win(1'b0, 1'b1);
    cool_mv <= MV_ZERO;
    wr(A_AT_HI, 16'h0000);
    heat_mv     <= MV_FULL;
    auto_tuning <= 1'b1;
    win(1'b0, 1'b0);
    auto_tuning <= 1'b0;
    win(1'b1, 1'b0);
    wr(A_AT_HI, AT_MAX);
    wr(A_AT_LO, MV_FULL);
    heat_mv     <= MV_ZERO;
    auto_tuning <= 1'b1;
    // Low limit lifts both MVs, so the idle cool side is driven too
    win(1'b1, 1'b1);
    auto_tuning <= 1'b0;
  endtask : t_pulse

  task automatic t_gating();
    heat_mv <= MV_FULL;
    cool_mv <= MV_FULL;
    rst(7'h06);
    win(1'b1, 1'b0);
    rst(7'h05);
    win(1'b1, 1'b0);
    rst(7'h03);
    win(1'b0, 1'b1);
    rc("status", A_STATUS, 16'h0032);
  endtask : t_gating

  // Main sequence
  initial begin
    // Reset from time zero so no check sees unknown state at edge one
    {srst, wr_stb, rd_stb, auto_tuning, clr} = 5'h10;
    {addr, wr_data} = 20'h0_0000;
    strap   = 7'h7E;
    pv      = 16'h0064;
    sp      = 16'h0064;
    heat_mv = 16'h0000;
    cool_mv = 16'h0000;
    rst(7'h7E);
    t_reset_relay();
    t_relay_limits();
    t_onoff();
    rst(7'h07);
    t_reset_plain();
    t_limits();
    t_units();
    t_pulse();
    t_gating();
    close_out();
  end
endmodule : testbench
